// ---- hw/cpc_map.vh ----
`ifndef CPC_MAP_VH
`define CPC_MAP_VH

// ----------------------------------------------------------------
// configuration mode codes on the mode pins
// ----------------------------------------------------------------
`define CPC_MODE_MSER    3'h0
`define CPC_MODE_SSER    3'h1
`define CPC_MODE_MPAR    3'h2
`define CPC_MODE_SPAR    3'h3
`define CPC_MODE_PERI    3'h4

// ----------------------------------------------------------------
// widths, defaults and reset values
// ----------------------------------------------------------------
`define CPC_ADDR_W       20
`define CPC_DATA_W       8
`define CPC_CNT_W        16
`define CPC_PREAMBLE     8'hA5
`define CPC_FRAME_LEN    16'h0010
`define CPC_BIT_LAST     3'h7
`define CPC_BIT_ZERO     3'h0
`define CPC_BYTE_ZERO    8'h00
`define CPC_ADDR_ZERO    20'h0_0000
`define CPC_ADDR_STEP    20'h0_0001
`define CPC_CNT_ZERO     16'h0000
`define CPC_CNT_STEP     16'h0001
`define CPC_BIT_STEP     3'h1

`endif

// ---- hw/cpc_config_port.v ----
// Function
// - low flag driven low throughout the configuration state.
// - after completion all configuration pins released to user logic.
// - error line pulled low on checksum mismatch or bad preamble.
// - after error wait in the error state until a restart is seen and program and reset are both high.
// - error line returns high when configuration resumes.
// - weak pull-up on error line enabled while configuring.
// - float input high: user pins high impedance, pull-downs on.
// - peripheral mode selected only when both active-low low, select high.
// - master parallel mode drives twenty-bit address to memory.
// - parallel modes take configuration data as eight-bit bytes.
// - serial data forwarded on chain output during configuration.
// - chain output changes only on falling configuration clock edge.
// - high flag driven high throughout the configuration state.
// - serial modes shift input bit on clock; parallel uses it as bit 0.
`timescale 1ns/1ns
`default_nettype none
`include "cpc_map.vh"

module cpc_config_port #(
  parameter                      ADDR_W    = `CPC_ADDR_W,
  parameter                      DATA_W    = `CPC_DATA_W,
  parameter [`CPC_DATA_W-1:0]    PREAMBLE  = `CPC_PREAMBLE,
  parameter [`CPC_CNT_W-1:0]     FRAME_LEN = `CPC_FRAME_LEN
) (
  input  wire                    sys_clk,
  input  wire                    rst_b,
  input  wire                    config_clock,
  input  wire                    program_request_n,
  input  wire                    device_reset_n,
  input  wire                    global_float_request,
  input  wire                    select_low_n,
  input  wire                    select_high,
  input  wire                    write_strobe_n,
  input  wire [2:0]              mode_select,
  input  wire                    serial_data_in,
  input  wire [DATA_W-1:1]       parallel_data_hi,
  output reg                     config_active_low_flag,
  output reg                     config_active_low_oe_n,
  output reg                     config_active_high_flag,
  output reg                     config_active_high_oe_n,
  output reg                     integrity_error_n,
  output reg                     integrity_error_oe_n,
  output reg                     integrity_error_pullup,
  output reg  [ADDR_W-1:0]       config_address,
  output reg                     config_address_oe_n,
  output reg                     chain_data_out,
  output reg                     chain_data_oe_n,
  output reg                     user_io_float,
  output reg                     user_io_pulldown,
  output reg                     config_done
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [1:0] ST_INIT = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_ERR  = 2'h2;
  localparam [1:0] ST_USER = 2'h3;

  localparam [1:0] PH_PRE  = 2'h0;
  localparam [1:0] PH_DATA = 2'h1;
  localparam [1:0] PH_SUM  = 2'h2;

  localparam SYNC_W = DATA_W + 10;

  // ----------------------------------------------------------------
  // two-stage synchronisers for every pin input
  // ----------------------------------------------------------------
  wire [SYNC_W-1:0] raw_in;
  reg  [SYNC_W-1:0] sync1;
  reg  [SYNC_W-1:0] sync2;
  reg               config_clock_prev;

  assign raw_in = {config_clock, program_request_n, device_reset_n,
                   global_float_request, select_low_n, select_high,
                   write_strobe_n, mode_select, parallel_data_hi,
                   serial_data_in};

  // sync stages
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1     <= {SYNC_W{1'b0}};
      sync2     <= {SYNC_W{1'b0}};
      config_clock_prev <= 1'b0;
    end else begin
      sync1     <= raw_in;
      sync2     <= sync1;
      config_clock_prev <= sync2[SYNC_W-1];
    end
  end

  wire              s_config_clock   = sync2[SYNC_W-1];
  wire              s_prog_n = sync2[SYNC_W-2];
  wire              s_rst_n  = sync2[SYNC_W-3];
  wire              s_float  = sync2[SYNC_W-4];
  wire              s_cs0_n  = sync2[SYNC_W-5];
  wire              s_cs1    = sync2[SYNC_W-6];
  wire              s_wr_n   = sync2[SYNC_W-7];
  wire [2:0]        s_mode   = sync2[SYNC_W-8:SYNC_W-10];
  wire [DATA_W-1:0] s_byte   = sync2[DATA_W-1:0]; // serial input is bit 0
  wire              s_din    = sync2[0];

  wire config_clock_rise = s_config_clock & ~config_clock_prev;
  wire config_clock_fall = ~s_config_clock & config_clock_prev;

  // ----------------------------------------------------------------
  // byte capture per mode
  // ----------------------------------------------------------------
  wire serial_mode = (s_mode == `CPC_MODE_MSER) | (s_mode == `CPC_MODE_SSER);
  wire selected    = ~s_cs0_n & ~s_wr_n & s_cs1;
  wire par_take    = ((s_mode == `CPC_MODE_MPAR) | (s_mode == `CPC_MODE_SPAR) |
                      ((s_mode == `CPC_MODE_PERI) & selected)) & config_clock_rise;

  reg  [1:0]        state;
  reg  [1:0]        next_state;
  reg  [1:0]        phase;
  reg  [2:0]        bit_cnt;
  reg  [DATA_W-1:0] shifter;
  reg  [DATA_W-1:0] checksum;
  reg  [`CPC_CNT_W-1:0] byte_cnt;
  reg               restart_seen;

  wire loading     = (state == ST_LOAD);
  wire ser_take    = serial_mode & config_clock_rise & loading;
  wire ser_full    = ser_take & (bit_cnt == `CPC_BIT_LAST);
  wire byte_valid  = loading & (ser_full | (par_take & ~serial_mode));
  wire [DATA_W-1:0] byte_val = serial_mode ? {shifter[DATA_W-2:0], s_din} : s_byte;

  wire pre_bad  = byte_valid & (phase == PH_PRE) & (byte_val != PREAMBLE);
  wire sum_bad  = byte_valid & (phase == PH_SUM) & (byte_val != checksum);
  wire sum_good = byte_valid & (phase == PH_SUM) & (byte_val == checksum);
  wire restart  = ~s_prog_n | ~s_rst_n;

  // ----------------------------------------------------------------
  // configuration state machine
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_INIT: begin
        if (s_prog_n & s_rst_n)
          next_state = ST_LOAD;
      end
      ST_LOAD: begin
        if (restart)
          next_state = ST_INIT;
        else if (pre_bad | sum_bad)
          next_state = ST_ERR;
        else if (sum_good)
          next_state = ST_USER;
      end
      ST_ERR: begin
        if (restart_seen & s_prog_n & s_rst_n)
          next_state = ST_LOAD;
      end
      ST_USER: begin
        if (restart)
          next_state = ST_INIT;
      end
      default: next_state = ST_INIT;
    endcase
  end

  // state, restart tracking while held in error
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= ST_INIT;
      restart_seen <= 1'b0;
    end else begin
      state <= next_state;
      if (state != ST_ERR)
        restart_seen <= 1'b0;
      else if (restart)
        restart_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // bit assembly, frame phase and running checksum
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt  <= `CPC_BIT_ZERO;
      shifter  <= `CPC_BYTE_ZERO;
      phase    <= PH_PRE;
      checksum <= `CPC_BYTE_ZERO;
      byte_cnt <= `CPC_CNT_ZERO;
    end else if (!loading) begin
      bit_cnt  <= `CPC_BIT_ZERO;
      shifter  <= `CPC_BYTE_ZERO;
      phase    <= PH_PRE;
      checksum <= `CPC_BYTE_ZERO;
      byte_cnt <= `CPC_CNT_ZERO;
    end else begin
      if (ser_take) begin
        shifter <= byte_val;
        bit_cnt <= bit_cnt + `CPC_BIT_STEP;
      end
      if (byte_valid) begin
        case (phase)
          PH_PRE: begin
            phase <= PH_DATA;
          end
          PH_DATA: begin
            checksum <= checksum ^ byte_val;
            byte_cnt <= byte_cnt + `CPC_CNT_STEP;
            if (byte_cnt == FRAME_LEN - `CPC_CNT_STEP)
              phase <= PH_SUM;
          end
          default: phase <= PH_PRE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers, all registered
  // ----------------------------------------------------------------
  wire master_par = (s_mode == `CPC_MODE_MPAR);

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      config_active_low_flag  <= 1'b1;
      config_active_low_oe_n  <= 1'b1;
      config_active_high_flag <= 1'b0;
      config_active_high_oe_n <= 1'b1;
      integrity_error_n       <= 1'b0;
      integrity_error_oe_n    <= 1'b1;
      integrity_error_pullup  <= 1'b0;
      config_address          <= `CPC_ADDR_ZERO;
      config_address_oe_n     <= 1'b1;
      chain_data_out          <= 1'b0;
      chain_data_oe_n         <= 1'b1;
      user_io_float           <= 1'b0;
      user_io_pulldown        <= 1'b0;
      config_done             <= 1'b0;
    end else begin
      // flags driven while configuring, released in user mode
      config_active_low_flag  <= 1'b0;
      config_active_high_flag <= 1'b1;
      config_active_low_oe_n  <= (next_state == ST_USER);
      config_active_high_oe_n <= (next_state == ST_USER);
      // error line: low drive only, pull-up while not in user mode
      integrity_error_n       <= 1'b0;
      integrity_error_oe_n    <= (next_state != ST_ERR);
      integrity_error_pullup  <= (next_state != ST_USER);
      // address bus only in master parallel loading
      config_address_oe_n     <= ~(master_par & (next_state == ST_LOAD));
      if (!loading)
        config_address <= `CPC_ADDR_ZERO;
      else if (master_par & byte_valid)
        config_address <= config_address + `CPC_ADDR_STEP;
      // chain output follows serial input, moved on falling edges
      chain_data_oe_n <= (next_state == ST_USER);
      if (config_clock_fall & serial_mode)
        chain_data_out <= s_din;
      // global float
      user_io_float    <= s_float;
      user_io_pulldown <= s_float;
      config_done      <= (next_state == ST_USER);
    end
  end

endmodule // cpc_config_port

`default_nettype wire

// ---- verif/cpc_config_port_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module cpc_config_port_props #(
  parameter ADDR_W = 20
) (
  input wire logic              sys_clk,
  input wire logic              rst_b,
  input wire logic              config_clock,
  input wire logic              program_request_n,
  input wire logic              device_reset_n,
  input wire logic              global_float_request,
  input wire logic [2:0]        mode_select,
  input wire logic              serial_data_in,
  input wire logic              config_active_low_flag,
  input wire logic              config_active_low_oe_n,
  input wire logic              config_active_high_flag,
  input wire logic              config_active_high_oe_n,
  input wire logic              integrity_error_n,
  input wire logic              integrity_error_oe_n,
  input wire logic              integrity_error_pullup,
  input wire logic [ADDR_W-1:0] config_address,
  input wire logic              config_address_oe_n,
  input wire logic              chain_data_out,
  input wire logic              chain_data_oe_n,
  input wire logic              user_io_float,
  input wire logic              user_io_pulldown,
  input wire logic              config_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // flag, error line and pin relations
  // ----------------------------------------------------------------
  property p_low_flag; $past(rst_b) && !config_done |->
    !config_active_low_oe_n && !config_active_low_flag; endproperty
  a_low_flag: assert property (p_low_flag) else $error("low flag not driven low");
  property p_high_flag; $past(rst_b) && !config_done |->
    !config_active_high_oe_n && config_active_high_flag; endproperty
  a_high_flag: assert property (p_high_flag) else $error("high flag not driven high");
  property p_release; config_done && $past(config_done) |-> config_active_low_oe_n &&
    config_active_high_oe_n && integrity_error_oe_n && config_address_oe_n && chain_data_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("pins not released");
  property p_open_drain; !integrity_error_oe_n |-> !integrity_error_n; endproperty
  a_open_drain: assert property (p_open_drain) else $error("error line driven high");
  property p_pullup; $past(rst_b) && !config_done |-> integrity_error_pullup; endproperty
  a_pullup: assert property (p_pullup) else $error("error pull-up off");
  property p_err_hold; (program_request_n && device_reset_n)[*8] ##0 !integrity_error_oe_n
    |=> !integrity_error_oe_n; endproperty
  a_err_hold: assert property (p_err_hold) else $error("error left without restart");
  property p_resume; $rose(integrity_error_oe_n) |-> program_request_n && device_reset_n; endproperty
  a_resume: assert property (p_resume) else $error("resume with restart pin low");
  property p_float; global_float_request[*5] |-> user_io_float && user_io_pulldown; endproperty
  a_float: assert property (p_float) else $error("float not applied");
  property p_addr; !config_address_oe_n && $past(!config_address_oe_n) && $changed(config_address)
    |-> config_address == $past(config_address) + 20'h0_0001; endproperty
  a_addr: assert property (p_addr) else $error("address step wrong");
  property p_addr_mode; !config_address_oe_n |-> mode_select == 3'h2; endproperty
  a_addr_mode: assert property (p_addr_mode) else $error("address driven in other mode");
  property p_chain; $changed(chain_data_out) && !chain_data_oe_n && $past(!chain_data_oe_n)
    |-> $past(config_clock, 3) == 1'b0; endproperty
  a_chain: assert property (p_chain) else $error("chain output moved off falling edge");
  // serial bit seen at a falling clock appears on the chain output
  property p_chain_fwd; $fell(config_clock) && mode_select < 3'h2
    |-> ##3 chain_data_out == $past(serial_data_in, 3); endproperty
  a_chain_fwd: assert property (p_chain_fwd) else $error("chain output not forwarded");
  // main scenarios reached
  c_done: cover property ($rose(config_done));
  c_err: cover property ($fell(integrity_error_oe_n));
  c_addr: cover property ($changed(config_address) && !config_address_oe_n);
endmodule // cpc_config_port_props
`default_nettype wire

// ---- verif/cpc_cfg_src.sv ----
`timescale 1ns/1ns
`default_nettype none
module cpc_cfg_src (
  input  wire logic       sys_clk,
  output var  logic       config_clock,
  output var  logic       serial_data_in,
  output var  logic [6:0] parallel_data_hi
);
  // clock stands low outside frames
  initial begin
    config_clock = 1'b0;
    {parallel_data_hi, serial_data_in} = 8'h00;
  end
  // one 320 ns clock period, data set mid low phase
  task automatic pulse(input logic [7:0] d);
    repeat (2) @(posedge sys_clk);
    {parallel_data_hi, serial_data_in} <= d;
    repeat (2) @(posedge sys_clk);
    config_clock <= 1'b1;
    repeat (4) @(posedge sys_clk);
    config_clock <= 1'b0;
  endtask
  // one byte, msb first when serial, whole byte when parallel
  task automatic send_byte(input logic [7:0] b, input logic ser);
    integer i;
    if (ser) for (i = 7; i >= 0; i--) pulse({~b[7:1], b[i]});
    else pulse(b);
    repeat (2) @(posedge sys_clk);
    {parallel_data_hi, serial_data_in} <= ~b; // released lines show inverse
  endtask
endmodule // cpc_cfg_src
`default_nettype wire

// ---- verif/cpc_config_port_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CPC_CHK(nm, e, g) begin #1; n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module cpc_config_port_tb;
  localparam [15:0] FLEN = 16'h0004;
  logic        sys_clk = 1'b0, rst_b, program_request_n, device_reset_n, global_float_request;
  logic        select_low_n, select_high, write_strobe_n, config_clock, serial_data_in;
  logic [2:0]  mode_select;
  logic [6:0]  parallel_data_hi, row;
  logic        lo_flag, lo_oe_n, hi_flag, hi_oe_n, err_n, err_oe_n, err_pu, addr_oe_n;
  logic        chain, chain_oe_n, fl, pd, done;
  logic [19:0] addr;
  wire         err_line = err_oe_n ? 1'b1 : err_n; // board pull-up on shared line
  int          n_checks = 0, n_mismatch = 0, r, k;
  // rows: mode, selected, fault (1 preamble, 2 checksum), done expected
  logic [6:0]  rows [8] = '{7'h09, 7'h19, 7'h29, 7'h39, 7'h49, 7'h40, 7'h1A, 7'h3C};
  always #20 sys_clk = ~sys_clk;
  cpc_cfg_src u_cpc_cfg_src (.sys_clk(sys_clk), .config_clock(config_clock),
    .serial_data_in(serial_data_in), .parallel_data_hi(parallel_data_hi));
  cpc_config_port #(.FRAME_LEN(FLEN)) u_cpc_config_port (.sys_clk(sys_clk), .rst_b(rst_b),
    .config_clock(config_clock), .program_request_n(program_request_n),
    .device_reset_n(device_reset_n), .global_float_request(global_float_request),
    .select_low_n(select_low_n), .select_high(select_high), .write_strobe_n(write_strobe_n),
    .mode_select(mode_select), .serial_data_in(serial_data_in),
    .parallel_data_hi(parallel_data_hi), .config_active_low_flag(lo_flag),
    .config_active_low_oe_n(lo_oe_n), .config_active_high_flag(hi_flag),
    .config_active_high_oe_n(hi_oe_n), .integrity_error_n(err_n),
    .integrity_error_oe_n(err_oe_n), .integrity_error_pullup(err_pu), .config_address(addr),
    .config_address_oe_n(addr_oe_n), .chain_data_out(chain), .chain_data_oe_n(chain_oe_n),
    .user_io_float(fl), .user_io_pulldown(pd), .config_done(done));
  // restart pulse on one of the two pins
  task automatic restart(input logic dev);
    if (dev) device_reset_n <= 1'b0;
    else program_request_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    device_reset_n <= 1'b1;
    program_request_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
  // preamble, data bytes, xor checksum, with optional fault
  task automatic send_frame(input logic [2:0] m, input logic [1:0] bad);
    logic [7:0] x, d;
    integer i;
    x = 8'h00;
    u_cpc_cfg_src.send_byte(bad == 2'h1 ? 8'h5A : 8'hA5, m < 3'h2);
    for (i = 0; i < FLEN; i++) begin
      d = 8'h11 * i[7:0] + 8'h03;
      x = x ^ d;
      u_cpc_cfg_src.send_byte(d, m < 3'h2);
    end
    u_cpc_cfg_src.send_byte(bad == 2'h2 ? ~x : x, m < 3'h2);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    {rst_b, global_float_request, mode_select} = 5'h00;
    {program_request_n, device_reset_n, select_low_n, select_high, write_strobe_n} = 5'h1B;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    `CPC_CHK("reset release", 3'h7, {lo_oe_n, err_oe_n, addr_oe_n})
    repeat (6) @(posedge sys_clk);
    for (r = 0; r < 8; r++) begin
      @(posedge sys_clk);
      row = rows[r];
      mode_select <= row[6:4];
      select_low_n <= ~row[3];
      write_strobe_n <= ~row[3];
      select_high <= row[3];
      restart(1'b0);
      `CPC_CHK("error released", 2'h3, {err_oe_n, err_pu})
      send_frame(row[6:4], row[2:1]);
      for (k = 0; k < 40 && done !== 1'b1 && err_oe_n !== 1'b0; k++) @(posedge sys_clk);
      if (k == 40 && row[2:0] != 3'h0) begin
        `CPC_CHK("wait bound", 1'b1, 1'b0)
        summarize();
      end
      repeat (2) @(posedge sys_clk);
      `CPC_CHK("done", row[0], done)
      `CPC_CHK("error line", row[2:1] == 2'h0, err_oe_n)
    end
    repeat (20) @(posedge sys_clk);
    `CPC_CHK("error held", 1'b0, err_oe_n)
    `CPC_CHK("error line level", 1'b0, err_line)
    @(posedge sys_clk);
    restart(1'b1);
    `CPC_CHK("error resumed", 1'b1, err_oe_n)
    @(posedge sys_clk);
    global_float_request <= 1'b1;
    repeat (6) @(posedge sys_clk);
    `CPC_CHK("float on", 2'h3, {fl, pd})
    @(posedge sys_clk);
    global_float_request <= 1'b0;
    repeat (6) @(posedge sys_clk);
    `CPC_CHK("float off", 2'h0, {fl, pd})
    summarize();
  end
endmodule // cpc_config_port_tb
bind cpc_config_port cpc_config_port_props #(.ADDR_W(ADDR_W)) u_props (.sys_clk, .rst_b,
  .config_clock, .program_request_n, .device_reset_n, .global_float_request, .mode_select,
  .serial_data_in,
  .config_active_low_flag, .config_active_low_oe_n, .config_active_high_flag,
  .config_active_high_oe_n, .integrity_error_n, .integrity_error_oe_n, .integrity_error_pullup,
  .config_address, .config_address_oe_n, .chain_data_out, .chain_data_oe_n, .user_io_float,
  .user_io_pulldown, .config_done);
`default_nettype wire
